/* File: dv/als_dec_model.sv */
`timescale 1ns/100ps
// ====
// Two-to-four digit decoder in front of the LED digits
module als_dec_model (
	// Select code from the block
	input  wire logic [1:0] sel_i,
	// One enable per digit
	output logic      [3:0] en_o
);
	assign en_o = 4'h1 << sel_i;
endmodule

/* File: dv/als_top_sva.sv */
`timescale 1ns/100ps
module als_top_sva #(
	parameter int CONV_CYCLES = 20,
	parameter int SCAN_CYCLES = 8
) (
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 rst_i,
	// Bus
	input  wire als_pkg::als_wb_req_t wb_i,
	input  wire als_pkg::als_wb_rsp_t wb_o,
	// Converter and display
	input  wire logic                 adc_start_o,
	input  wire logic                 adc_done_i,
	input  wire logic [9:0]           analog_input_zero_i,
	input  wire logic [7:0]           segment_out_o,
	input  wire logic [1:0]           digit_select_o
);
	import als_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ====
	// Converter pacing
	property p_start_gap;
		adc_start_o |=> !adc_start_o [*8];
	endproperty
	a_start_gap: assert property (p_start_gap)
		else $error("start pulses too close");
	// ====
	// Display
	property p_pat;
		segment_out_o != 8'h00 |-> segment_out_o[6:0] inside {7'h3F, 7'h06,
			7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h27, 7'h7F, 7'h6F};
	endproperty
	a_pat: assert property (p_pat)
		else $error("illegal segment pattern");
	property p_dp;
		segment_out_o != 8'h00 |->
			segment_out_o[7] == (digit_select_o == 2'h1);
	endproperty
	a_dp: assert property (p_dp)
		else $error("decimal point misplaced");
	property p_blank;
		$changed(digit_select_o) |-> $past(segment_out_o) == 8'h00;
	endproperty
	a_blank: assert property (p_blank)
		else $error("select changed while lit");
	property p_desc;
		$changed(digit_select_o) |->
			digit_select_o == $past(digit_select_o) - 2'h1;
	endproperty
	a_desc: assert property (p_desc)
		else $error("scan order wrong");
	property p_hold;
		$changed(digit_select_o) |=> $stable(digit_select_o) [*7];
	endproperty
	a_hold: assert property (p_hold)
		else $error("digit advanced too soon");
	property p_seg_on;
		$changed(digit_select_o) |=> segment_out_o != 8'h00;
	endproperty
	a_seg_on: assert property (p_seg_on)
		else $error("digit not lit after switch");
	// ====
	// Bus handshake
	property p_ack;
		wb_i.cyc && wb_i.stb && !wb_o.ack |=> wb_o.ack ##1 !wb_o.ack;
	endproperty
	a_ack: assert property (p_ack)
		else $error("ack not a one-cycle answer");
endmodule

bind als_top als_top_sva #(
	.CONV_CYCLES(CONV_CYCLES),
	.SCAN_CYCLES(SCAN_CYCLES)
) als_top_sva_inst (.clk_i, .rst_i, .wb_i, .wb_o, .adc_start_o, .adc_done_i,
	.analog_input_zero_i, .segment_out_o, .digit_select_o);

/* File: dv/testbench.sv */
`timescale 1ns/100ps
module testbench;
	import als_pkg::*;
	localparam int CC = 20;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	als_wb_req_t wb_i = '0;
	als_wb_rsp_t wb_o;
	logic        adc_start_o;
	logic        adc_done_i = 1'b0;
	logic [9:0]  adc_dat = 10'h000;
	logic [7:0]  seg;
	logic [1:0]  sel;
	logic [3:0]  en;
	logic [31:0] rd;
	int          err_total = 0;
	int          n_checks = 0;
	int          cyc = 0;
	int          last = 0;
	int          gap;
	// Result in, expected BCD digits out
	logic [25:0] rows [5] = '{{10'h3FF, 16'h1023}, {10'h1C8, 16'h0456},
		{10'h30A, 16'h0778}, {10'h3E7, 16'h0999}, {10'h000, 16'h0000}};
	logic [7:0]  pat [10] = '{8'h3F, 8'h06, 8'h5B, 8'h4F, 8'h66, 8'h6D,
		8'h7D, 8'h27, 8'h7F, 8'h6F};
	always #5 clk_i = ~clk_i;
	always @(posedge clk_i) cyc++;
	als_top #(.CONV_CYCLES(CC), .SCAN_CYCLES(8)) als_top_inst (.clk_i,
		.rst_i, .wb_i, .wb_o, .adc_start_o, .adc_done_i,
		.analog_input_zero_i(adc_dat), .segment_out_o(seg),
		.digit_select_o(sel));
	als_dec_model als_dec_model_inst (.sel_i(sel), .en_o(en));
	task report_and_stop;
		$display("checks %0d errors %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			err_total++;
			$display("[ERR] %0t got %h want %h", $time, s, e);
		end
	endtask
	task tmo(input int i, input int lim);
		if (i >= lim) begin
			err_total++;
			report_and_stop();
		end
	endtask
	// Holds the request until the edge that samples ack
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int i;
		wb_i <= '{1'b1, 1'b1, we, 4'hF, a, d};
		for (i = 0; i < 20; i++) begin
			@(posedge clk_i);
			if (wb_o.ack === 1'b1) break;
		end
		tmo(i, 20);
		rd = wb_o.dat;
		wb_i <= '0;
		@(posedge clk_i);
	endtask
	task wait_start;
		int i;
		// Step past a pulse that may still stand from the last call
		@(negedge clk_i);
		for (i = 0; i < 20 * CC && adc_start_o !== 1'b1; i++)
			@(negedge clk_i);
		tmo(i, 20 * CC);
		gap = cyc - last;
		last = cyc;
	endtask
	task show(input logic [15:0] b);
		int k, i;
		// Start after a blank so no pattern of the old value is seen
		@(negedge clk_i);
		for (i = 0; i < 60 && seg !== 8'h00; i++)
			@(negedge clk_i);
		tmo(i, 60);
		for (k = 3; k >= 0; k--) begin
			for (i = 0; i < 60 && !(sel === k[1:0] && seg !== 8'h00); i++)
				@(negedge clk_i);
			tmo(i, 60);
			chk(seg, pat[b[k*4+:4]] | (k == 1 ? 8'h80 : 8'h00));
			chk(en, 4'h1 << k);
		end
	endtask
	initial begin
		int r, i;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk(seg, 8'h00);
		chk(sel, 2'h3);
		@(posedge clk_i);
		wb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h1);
		wb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h0);
		wb(1'b1, 8'h08, 32'h155);
		wb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'h0);
		wb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h30);
		$display("registers done");
		wait_start();
		chk(seg, 8'h00);
		for (r = 0; r < 5; r++) begin
			wait_start();
			chk(gap, 15 * CC);
			@(posedge clk_i);
			adc_done_i <= 1'b0;
			adc_dat <= rows[r][25:16];
			repeat (3) @(posedge clk_i);
			adc_done_i <= 1'b1;
			for (i = 0; i < 30 && rd[15:0] !== rows[r][15:0]; i++)
				wb(1'b0, 8'h0C, 32'h0);
			chk(rd, {16'h0, rows[r][15:0]});
			show(rows[r][15:0]);
			wb(1'b0, 8'h08, 32'h0);
			chk(rd, {22'h0, rows[r][25:16]});
			$display("row %0d done", r);
		end
		wb(1'b1, 8'h00, 32'h0);
		wb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0);
		for (i = 0; i < 20 * CC; i++) begin
			@(negedge clk_i);
			chk(adc_start_o, 1'b0);
		end
		$display("freeze done");
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(negedge clk_i);
		chk({seg, sel}, 10'h003);
		@(posedge clk_i);
		wb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h1);
		$display("reset done");
		report_and_stop();
	end
endmodule

/* File: hw/als_consts.svh */
`ifndef ALS_CONSTS_SVH
`define ALS_CONSTS_SVH

// ==========================================================
// Timing
`define ALS_CLK_PERIOD_NS       10
`define ALS_CONV_PERIOD_NS      32768000
`define ALS_SCAN_PERIOD_NS      2048000
`define ALS_CONV_CYCLES         (`ALS_CONV_PERIOD_NS / `ALS_CLK_PERIOD_NS)
`define ALS_SCAN_CYCLES         (`ALS_SCAN_PERIOD_NS / `ALS_CLK_PERIOD_NS)
// 0.49152 s sample period divided by the 32.768 ms overflow period
`define ALS_OVF_PER_SAMPLE      4'hF

// ==========================================================
// Register map (byte addresses)
`define ALS_ADR_CTRL            8'h00
`define ALS_ADR_STATUS          8'h04
`define ALS_ADR_RESULT          8'h08
`define ALS_ADR_DIGITS          8'h0C
`define ALS_CTRL_RUN_BIT        0
`define ALS_CTRL_RESET          1'b1
`define ALS_STAT_VALID_BIT      0
`define ALS_STAT_BUSY_BIT       1
`define ALS_STAT_SEL_LSB        4

// ==========================================================
// Segment patterns, bit 7 is the decimal point
`define ALS_SEG_0               8'h3F
`define ALS_SEG_1               8'h06
`define ALS_SEG_2               8'h5B
`define ALS_SEG_3               8'h4F
`define ALS_SEG_4               8'h66
`define ALS_SEG_5               8'h6D
`define ALS_SEG_6               8'h7D
`define ALS_SEG_7               8'h27
`define ALS_SEG_8               8'h7F
`define ALS_SEG_9               8'h6F
`define ALS_SEG_DP              8'h80
`define ALS_SEG_BLANK           8'h00
`define ALS_DIGIT_FOUR          2'h3
`define ALS_DP_DIGIT            2'h1

`endif

/* File: hw/als_pkg.sv */
package als_pkg;

	// ==========================================================
	// Bus carriers
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} als_wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} als_wb_rsp_t;

	// ==========================================================
	// Display scan states
	typedef enum logic [1:0] {
		ALS_ST_WAIT,
		ALS_ST_SHOW,
		ALS_ST_BLANK,
		ALS_ST_SWITCH
	} als_scan_st_t;

endpackage

/* File: hw/als_top.sv */
// Local design decisions: the placing of the registers and the Wishbone register port.
`timescale 1ns/100ps
`include "als_consts.svh"

module als_top #(
	parameter int CONV_CYCLES = `ALS_CONV_CYCLES,
	parameter int SCAN_CYCLES = `ALS_SCAN_CYCLES
) (
	// Clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// Wishbone slave
	input  wire als_pkg::als_wb_req_t wb_i,
	output als_pkg::als_wb_rsp_t    wb_o,
	// Converter
	output logic                    adc_start_o,
	input  wire logic               adc_done_i,
	input  wire logic [9:0]         analog_input_zero_i,
	// Display
	output logic [7:0]              segment_out_o,
	output logic [1:0]              digit_select_o
);
	import als_pkg::*;

	// ==========================================================
	// Helpers
	function automatic logic [7:0] seg_of(input logic [3:0] d);
		case (d)
			4'h0: seg_of = `ALS_SEG_0;
			4'h1: seg_of = `ALS_SEG_1;
			4'h2: seg_of = `ALS_SEG_2;
			4'h3: seg_of = `ALS_SEG_3;
			4'h4: seg_of = `ALS_SEG_4;
			4'h5: seg_of = `ALS_SEG_5;
			4'h6: seg_of = `ALS_SEG_6;
			4'h7: seg_of = `ALS_SEG_7;
			4'h8: seg_of = `ALS_SEG_8;
			4'h9: seg_of = `ALS_SEG_9;
			default: seg_of = `ALS_SEG_BLANK;
		endcase
	endfunction

	// Result counts tenths; 1023 max shows as 102.3, well inside 999.9
	function automatic logic [15:0] to_bcd(input logic [9:0] v);
		logic [3:0] d0;
		logic [3:0] d1;
		logic [3:0] d2;
		logic [3:0] d3;
		d0 = 4'(v % 10);
		d1 = 4'((v / 10) % 10);
		d2 = 4'((v / 100) % 10);
		d3 = 4'(v / 1000);
		to_bcd = {d3, d2, d1, d0};
	endfunction

	// ==========================================================
	// Input synchronisers
	logic       done_m;
	logic       done_s;
	logic [9:0] data_m;
	logic [9:0] data_s;

	always_ff @(posedge clk_i) begin
		done_m <= adc_done_i;
		done_s <= done_m;
		data_m <= analog_input_zero_i;
		data_s <= data_m;
	end

	// ==========================================================
	// Conversion pacing and result capture
	logic [21:0] conv_cnt;
	logic [21:0] next_conv_cnt;
	logic [3:0]  ovf_cnt;
	logic [3:0]  next_ovf_cnt;
	logic        busy;
	logic        next_busy;
	logic        valid;
	logic        next_valid;
	logic        start;
	logic        next_start;
	logic [9:0]  result;
	logic [9:0]  next_result;
	logic [15:0] digits;
	logic [15:0] next_digits;
	logic        run;
	logic        conv_ovf;

	assign conv_ovf = run && (conv_cnt == 22'(CONV_CYCLES - 1));

	always_comb begin
		next_conv_cnt = conv_cnt;
		next_ovf_cnt  = ovf_cnt;
		next_busy     = busy;
		next_valid    = valid;
		next_start    = 1'b0;
		next_result   = result;
		next_digits   = digits;
		if (run) begin
			next_conv_cnt = conv_ovf ? 22'h0 : conv_cnt + 22'h1;
		end
		if (conv_ovf) begin
			// Done is only looked at here, never as an event of its own
			if (busy && done_s) begin
				next_busy   = 1'b0;
				next_valid  = 1'b1;
				next_result = data_s;
				next_digits = to_bcd(data_s);
			end
			if (ovf_cnt == `ALS_OVF_PER_SAMPLE - 4'h1) begin
				next_ovf_cnt = 4'h0;
				next_start   = 1'b1;
				next_busy    = 1'b1;
			end else begin
				next_ovf_cnt = ovf_cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conv_cnt <= 22'h0;
			ovf_cnt  <= 4'h0;
			busy     <= 1'b0;
			valid    <= 1'b0;
			start    <= 1'b0;
			result   <= 10'h0;
			digits   <= 16'h0;
		end else begin
			conv_cnt <= next_conv_cnt;
			ovf_cnt  <= next_ovf_cnt;
			busy     <= next_busy;
			valid    <= next_valid;
			start    <= next_start;
			result   <= next_result;
			digits   <= next_digits;
		end
	end

	assign adc_start_o = start;

	// ==========================================================
	// Display scan
	als_scan_st_t st;
	als_scan_st_t next_st;
	logic [21:0]  scan_cnt;
	logic [21:0]  next_scan_cnt;
	logic [1:0]   sel;
	logic [1:0]   next_sel;
	logic [7:0]   seg;
	logic [7:0]   next_seg;
	logic         scan_ovf;
	logic [3:0]   cur_digit;
	logic [7:0]   cur_pat;

	assign scan_ovf  = (scan_cnt == 22'(SCAN_CYCLES - 1));
	// Select already holds the new digit whenever a pattern is loaded
	assign cur_digit = digits[{sel, 2'b00} +: 4];
	assign cur_pat   = seg_of(cur_digit)
		| ((sel == `ALS_DP_DIGIT) ? `ALS_SEG_DP : `ALS_SEG_BLANK);

	always_comb begin
		next_st       = st;
		next_sel      = sel;
		next_seg      = seg;
		next_scan_cnt = scan_ovf ? 22'h0 : scan_cnt + 22'h1;
		case (st)
			ALS_ST_WAIT: begin
				next_scan_cnt = 22'h0;
				next_sel      = `ALS_DIGIT_FOUR;
				next_seg      = `ALS_SEG_BLANK;
				if (valid) begin
					next_st  = ALS_ST_SHOW;
					next_seg = cur_pat;
				end
			end
			ALS_ST_SHOW: begin
				if (scan_ovf) begin
					// Dark for two cycles (BLANK and SWITCH) so the old pattern never ghosts
					next_seg = `ALS_SEG_BLANK;
					next_st  = ALS_ST_BLANK;
				end
			end
			ALS_ST_BLANK: begin
				next_sel = sel - 2'h1;
				next_st  = ALS_ST_SWITCH;
			end
			ALS_ST_SWITCH: begin
				next_seg = cur_pat;
				next_st  = ALS_ST_SHOW;
			end
			default: begin
				next_st = ALS_ST_WAIT;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st       <= ALS_ST_WAIT;
			scan_cnt <= 22'h0;
			sel      <= `ALS_DIGIT_FOUR;
			seg      <= `ALS_SEG_BLANK;
		end else begin
			st       <= next_st;
			scan_cnt <= next_scan_cnt;
			sel      <= next_sel;
			seg      <= next_seg;
		end
	end

	assign segment_out_o  = seg;
	assign digit_select_o = sel;

	// ==========================================================
	// Wishbone slave, one wait state, unmapped reads as zero
	logic        ack;
	logic        next_ack;
	logic [31:0] rdat;
	logic [31:0] next_rdat;
	logic        next_run;
	logic        req;

	assign req = wb_i.cyc && wb_i.stb && !ack;

	always_comb begin
		next_ack  = req;
		next_rdat = rdat;
		next_run  = run;
		// Write lands on the edge at which the master sees ack
		if (ack && wb_i.cyc && wb_i.stb && wb_i.we && wb_i.sel[0]
			&& wb_i.adr == `ALS_ADR_CTRL) begin
			next_run = wb_i.dat[`ALS_CTRL_RUN_BIT];
		end
		if (req && !wb_i.we) begin
			next_rdat = 32'h0;
			case (wb_i.adr)
				`ALS_ADR_CTRL: begin
					next_rdat[`ALS_CTRL_RUN_BIT] = run;
				end
				`ALS_ADR_STATUS: begin
					next_rdat[`ALS_STAT_VALID_BIT] = valid;
					next_rdat[`ALS_STAT_BUSY_BIT]  = busy;
					next_rdat[`ALS_STAT_SEL_LSB +: 2] = sel;
				end
				`ALS_ADR_RESULT: begin
					next_rdat[9:0] = result;
				end
				`ALS_ADR_DIGITS: begin
					next_rdat[15:0] = digits;
				end
				default: begin
					next_rdat = 32'h0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack  <= 1'b0;
			rdat <= 32'h0;
			run  <= `ALS_CTRL_RESET;
		end else begin
			ack  <= next_ack;
			rdat <= next_rdat;
			run  <= next_run;
		end
	end

	assign wb_o.ack = ack;
	assign wb_o.dat = rdat;

endmodule
